// *** hdl/aer_pkg.sv ***
// constants for the advanced error reporting register bank
package aer_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CAP_HDR = 12'hFB4;
  localparam logic [11:0] ADDR_UNC_STATUS = 12'hFB8;
  localparam logic [11:0] ADDR_UNC_MASK = 12'hFBC;
  localparam logic [11:0] ADDR_UNC_SEVERITY = 12'hFC0;
  localparam logic [11:0] ADDR_COR_STATUS = 12'hFC4;
  localparam logic [11:0] ADDR_COR_MASK = 12'hFC8;
  localparam logic [11:0] ADDR_CAP_CTRL = 12'hFCC;
  localparam logic [11:0] ADDR_ROOT_CMD = 12'hFE0;
  localparam logic [11:0] ADDR_ROOT_STATUS = 12'hFE4;
  localparam logic [11:0] ADDR_SOURCE_ID = 12'hFE8;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'hF00;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'hF04;

  // ----------------------------------------------------------------
  // capability header fields
  // ----------------------------------------------------------------
  localparam logic [15:0] CAP_ID = 16'h0001;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] CAP_NEXT = 12'h138;

  // ----------------------------------------------------------------
  // uncorrectable bit layout
  // ----------------------------------------------------------------
  localparam int UNC_DLP = 4;
  localparam int UNC_SURPRISE = 5;
  localparam int UNC_POISON = 12;
  localparam int UNC_FCP = 13;
  localparam int UNC_CPL_TIMEOUT = 14;
  localparam int UNC_CPL_ABORT = 15;
  localparam int UNC_UNEXP_CPL = 16;
  localparam int UNC_RX_OVERFLOW = 17;
  localparam int UNC_MALFORMED = 18;
  localparam int UNC_ECRC = 19;
  localparam int UNC_UNSUP_REQ = 20;
  localparam int UNC_INTERNAL = 22;
  // implemented status bits, internal error added on port 0
  localparam logic [31:0] UNC_IMPL = 32'h0017_D030;
  localparam logic [31:0] UNC_INT_BIT = 32'h0040_0000;
  localparam logic [31:0] UNC_MASK_RST = 32'h0040_0000;
  localparam logic [31:0] UNC_SEV_RST = 32'h0046_2030;
  localparam logic [31:0] UNC_FCP_BIT = 32'h0000_2000;
  // errors that go advisory when severity is non-fatal
  localparam logic [31:0] UNC_ADVISORY = 32'h0011_D000;

  // ----------------------------------------------------------------
  // correctable bit layout
  // ----------------------------------------------------------------
  localparam int COR_ADVISORY = 13;
  localparam int COR_INTERNAL = 14;
  localparam int COR_HDR_OVF = 15;
  localparam logic [31:0] COR_IMPL = 32'h0000_B1C1;
  localparam logic [31:0] COR_INT_BIT = 32'h0000_4000;
  localparam logic [31:0] COR_MASK_RST = 32'h0000_E000;

  // ----------------------------------------------------------------
  // capabilities and control
  // ----------------------------------------------------------------
  localparam logic [4:0] FIRST_PTR_RST = 5'h1F;

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  localparam int IRQ_UNC = 0;
  localparam int IRQ_COR = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [2:0] {
    MSG_IDLE = 3'b001,
    MSG_SEND = 3'b010,
    MSG_WAIT = 3'b100
  } msg_state_t;

  typedef enum logic [1:0] {
    MSG_COR = 2'h0,
    MSG_NONFATAL = 2'h1,
    MSG_FATAL = 2'h2
  } msg_kind_t;
endpackage

// *** hdl/pcie_advanced_error_reporting.sv ***
// advanced error reporting register bank with apb access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pcie_advanced_error_reporting #(
  parameter bit PORT_ZERO = 1'b1
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic auxPowerRst,
  // strap
  input wire logic rootMode,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // error events, one-cycle pulses
  input wire logic [31:0] uncErrEvent,
  input wire logic [31:0] corErrEvent,
  // message toward root complex
  output logic msgValid,
  output aer_pkg::msg_kind_t msgKind,
  input wire logic msgAccept,
  // header log capture strobe
  output logic hdrLogCapture,
  // interrupt
  output logic irq
);
  import aer_pkg::*;

  // ----------------------------------------------------------------
  // port dependent layouts
  // ----------------------------------------------------------------
  // ecrc bit 19 never live, stays zero
  localparam logic [31:0] UNC_LIVE = PORT_ZERO ? (UNC_IMPL | UNC_INT_BIT) : UNC_IMPL;
  localparam logic [31:0] COR_LIVE = PORT_ZERO ? (COR_IMPL | COR_INT_BIT) : COR_IMPL;

  logic [31:0] uncStatus_ff, uncMask_ff, uncSev_ff, corStatus_ff, corMask_ff;
  logic [4:0] firstPtr_ff;
  logic [31:0] rootCmd_ff;
  logic [IRQ_W-1:0] irqStatus_ff, irqMask_ff;
  logic rootMode_ff;
  msg_state_t msgState_ff;
  logic [1:0] pendFatal_ff, pendNonFatal_ff, pendCor_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wrEn, rdEn;
  logic [31:0] wmask;
  assign wrEn = psel && penable && pwrite && pready;
  // read data latched in setup, shown in access
  assign rdEn = psel && !penable && !pwrite;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  logic [31:0] w1c;
  assign w1c = pwdata & wmask;

  // ----------------------------------------------------------------
  // error classification
  // ----------------------------------------------------------------
  logic [31:0] uncHit, uncReport, uncFatal, uncAdvis, uncNonFatal, corHit, corReport;
  logic advisoryHit;
  assign uncHit = uncErrEvent & UNC_LIVE;
  assign uncReport = uncHit & ~uncMask_ff;
  assign uncFatal = uncReport & uncSev_ff;
  assign uncAdvis = uncReport & ~uncSev_ff & UNC_ADVISORY;
  assign uncNonFatal = uncReport & ~uncSev_ff & ~UNC_ADVISORY;
  assign advisoryHit = |uncAdvis;
  // advisory error raises correctable bit 13
  assign corHit = (corErrEvent & COR_LIVE)
                | (advisoryHit ? (32'h1 << COR_ADVISORY) : 32'h0);
  assign corReport = corHit & ~corMask_ff;

  // ----------------------------------------------------------------
  // sticky registers, cleared only by aux power reset; header log strobe cleared by sys_rst
  // ----------------------------------------------------------------
  // sticky fields ignore sys_rst
  // uncorrectable status, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      uncStatus_ff <= 32'h0;
    end else if (wrEn && paddr == ADDR_UNC_STATUS) begin
      uncStatus_ff <= ((uncStatus_ff & ~w1c) | uncHit) & UNC_LIVE;
    end else begin
      uncStatus_ff <= (uncStatus_ff | uncHit) & UNC_LIVE;
    end
  end

  // mask sticky, only live bits writable
  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      uncMask_ff <= UNC_MASK_RST;
    end else if (wrEn && paddr == ADDR_UNC_MASK) begin
      uncMask_ff <= (uncMask_ff & ~(wmask & UNC_LIVE)) | (pwdata & wmask & UNC_LIVE);
    end
  end

  // bit 13 kept at one from reset
  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      uncSev_ff <= UNC_SEV_RST;
    end else if (wrEn && paddr == ADDR_UNC_SEVERITY) begin
      uncSev_ff <= (uncSev_ff & ~(wmask & UNC_LIVE)) | (pwdata & wmask & UNC_LIVE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      corStatus_ff <= 32'h0;
    end else if (wrEn && paddr == ADDR_COR_STATUS) begin
      corStatus_ff <= ((corStatus_ff & ~w1c) | corHit) & COR_LIVE;
    end else begin
      corStatus_ff <= (corStatus_ff | corHit) & COR_LIVE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      corMask_ff <= COR_MASK_RST;
    end else if (wrEn && paddr == ADDR_COR_MASK) begin
      corMask_ff <= (corMask_ff & ~(wmask & COR_LIVE)) | (pwdata & wmask & COR_LIVE);
    end
  end

  // first error pointer, lowest reported bit wins a tie
  logic [4:0] nxt_firstPtr;
  always_comb begin
    nxt_firstPtr = firstPtr_ff;
    for (int i = 31; i >= 0; i--) begin
      if (uncReport[i]) begin
        nxt_firstPtr = 5'(i);
      end
    end
  end
  // pointer moves only on unmasked error while empty
  // pointer freed once its status bit clears
  always_ff @(posedge sys_clk) begin
    if (auxPowerRst) begin
      firstPtr_ff <= FIRST_PTR_RST;
    end else if (|uncReport && firstPtr_ff == FIRST_PTR_RST) begin
      firstPtr_ff <= nxt_firstPtr;
    end else if (firstPtr_ff != FIRST_PTR_RST && !uncStatus_ff[firstPtr_ff]) begin
      firstPtr_ff <= FIRST_PTR_RST;
    end
  end

  // header log only for unmasked errors
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hdrLogCapture <= 1'b0;
    end else begin
      hdrLogCapture <= |uncReport && firstPtr_ff == FIRST_PTR_RST;
    end
  end

  // ----------------------------------------------------------------
  // ordinary registers
  // ----------------------------------------------------------------
  // strap sampled into a flop, seen one cycle late
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rootMode_ff <= 1'b0;
    end else begin
      rootMode_ff <= rootMode;
    end
  end

  // root command writable in root mode only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rootCmd_ff <= 32'h0;
    end else if (wrEn && rootMode_ff && paddr == ADDR_ROOT_CMD) begin
      rootCmd_ff <= (rootCmd_ff & ~(wmask & 32'h7)) | (pwdata & wmask & 32'h7);
    end
  end

  // ----------------------------------------------------------------
  // message sender
  // ----------------------------------------------------------------
  // pending message counts per class, saturating at one pending
  logic anyFatal, anyNonFatal, anyCor;
  assign anyFatal = |uncFatal;
  assign anyNonFatal = |uncNonFatal;
  assign anyCor = |corReport;
  logic sentFatal, sentNonFatal, sentCor;
  assign sentFatal = msgValid && msgAccept && msgKind == MSG_FATAL;
  assign sentNonFatal = msgValid && msgAccept && msgKind == MSG_NONFATAL;
  assign sentCor = msgValid && msgAccept && msgKind == MSG_COR;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pendFatal_ff <= 2'h0;
      pendNonFatal_ff <= 2'h0;
      pendCor_ff <= 2'h0;
    end else begin
      pendFatal_ff <= {1'b0, anyFatal | (pendFatal_ff[0] & ~sentFatal)};
      pendNonFatal_ff <= {1'b0, anyNonFatal | (pendNonFatal_ff[0] & ~sentNonFatal)};
      pendCor_ff <= {1'b0, anyCor | (pendCor_ff[0] & ~sentCor)};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      msgState_ff <= MSG_IDLE;
      msgValid <= 1'b0;
      msgKind <= MSG_COR;
    end else begin
      case (msgState_ff)
        MSG_IDLE: begin
          if (pendFatal_ff[0] || pendNonFatal_ff[0] || pendCor_ff[0]) begin
            msgState_ff <= MSG_SEND;
            msgValid <= 1'b1;
            msgKind <= pendFatal_ff[0] ? MSG_FATAL
                     : pendNonFatal_ff[0] ? MSG_NONFATAL : MSG_COR;
          end
        end
        MSG_SEND: begin
          if (msgAccept) begin
            msgValid <= 1'b0;
            msgState_ff <= MSG_WAIT;
          end
        end
        MSG_WAIT: begin
          msgState_ff <= MSG_IDLE;
        end
        default: begin
          msgState_ff <= MSG_IDLE;
          msgValid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irqEvent;
  // bit 0 uncorrectable message, bit 1 correctable
  assign irqEvent = {anyCor, anyFatal | anyNonFatal};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqStatus_ff <= '0;
    end else if (wrEn && paddr == ADDR_IRQ_STATUS) begin
      irqStatus_ff <= (irqStatus_ff & ~w1c[IRQ_W-1:0]) | irqEvent;
    end else begin
      irqStatus_ff <= irqStatus_ff | irqEvent;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqMask_ff <= '0;
    end else if (wrEn && paddr == ADDR_IRQ_MASK && pstrb[0]) begin
      irqMask_ff <= pwdata[IRQ_W-1:0];
    end
  end
  // level output, one cycle behind status
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_ff & irqMask_ff);
    end
  end

  // ----------------------------------------------------------------
  // read path, data ready one cycle after setup
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    case (paddr)
      ADDR_CAP_HDR: rdMux = {CAP_NEXT, CAP_VERSION, CAP_ID};
      ADDR_UNC_STATUS: rdMux = uncStatus_ff | UNC_FCP_BIT;
      ADDR_UNC_MASK: rdMux = uncMask_ff;
      ADDR_UNC_SEVERITY: rdMux = uncSev_ff | UNC_FCP_BIT;
      ADDR_COR_STATUS: rdMux = corStatus_ff;
      ADDR_COR_MASK: rdMux = corMask_ff;
      ADDR_CAP_CTRL: rdMux = {27'h0, firstPtr_ff};
      ADDR_ROOT_CMD: rdMux = rootMode_ff ? rootCmd_ff : 32'h0;
      // root status and source id not modelled
      ADDR_ROOT_STATUS: rdMux = 32'h0;
      ADDR_SOURCE_ID: rdMux = 32'h0;
      ADDR_IRQ_STATUS: rdMux = {{(32-IRQ_W){1'b0}}, irqStatus_ff};
      ADDR_IRQ_MASK: rdMux = {{(32-IRQ_W){1'b0}}, irqMask_ff};
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rdEn) begin
        prdata <= rdMux;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/aer_checker.sv ***
// port-level checks for the error reporting bank
`timescale 1ns/1ps
`default_nettype none
module aer_checker
  import aer_pkg::*;
(
  // clock and resets
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic auxPowerRst,
  input wire logic rootMode,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and messages
  input wire logic [31:0] uncErrEvent,
  input wire logic [31:0] corErrEvent,
  input wire logic msgValid,
  input wire aer_pkg::msg_kind_t msgKind,
  input wire logic msgAccept,
  input wire logic hdrLogCapture,
  input wire logic irq
);
  logic rdAcc;
  logic anyUnc;
  assign rdAcc = psel && penable && pready && !pwrite;
  assign anyUnc = |uncErrEvent;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst || auxPowerRst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_ACCESS_READY: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  AST_NO_SLVERR: assert property (!pslverr)
    else $error("slave error raised");
  AST_CAP_HDR: assert property (rdAcc && paddr == ADDR_CAP_HDR |-> prdata == 32'h1381_0001)
    else $error("capability header wrong");
  AST_FCP_ONE: assert property (rdAcc && paddr inside {12'hFB8, 12'hFC0} |-> prdata[13])
    else $error("flow control bit not one");
  AST_ECRC_ZERO: assert property (rdAcc && paddr inside {12'hFB8, 12'hFBC, 12'hFC0}
    |-> !prdata[19])
    else $error("ecrc bit not zero");
  AST_CTRL_ZERO: assert property (rdAcc && paddr == ADDR_CAP_CTRL |-> prdata[31:5] == 27'h0)
    else $error("control upper bits not zero");
  AST_ROOT_RSVD: assert property (rdAcc && paddr inside {12'hFE0, 12'hFE4, 12'hFE8} && !rootMode
    && !$past(rootMode) && !$past(rootMode, 2) |-> prdata == 32'h0)
    else $error("root register visible in adapter mode");
  AST_LOG_CAUSE: assert property (hdrLogCapture |-> $past(anyUnc))
    else $error("header log without error");
  AST_LOG_PULSE: assert property (hdrLogCapture |=> !hdrLogCapture)
    else $error("header log pulse too long");
  AST_MSG_HOLD: assert property (msgValid && !msgAccept |=> msgValid && $stable(msgKind))
    else $error("message dropped before accept");
  AST_MSG_GAP: assert property (msgValid && msgAccept |=> !msgValid)
    else $error("no idle cycle after message");
  COV_FATAL: cover property (msgValid && msgAccept && msgKind == MSG_FATAL);
  COV_NONFATAL: cover property (msgValid && msgAccept && msgKind == MSG_NONFATAL);
  COV_COR: cover property (msgValid && msgAccept && msgKind == MSG_COR);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind pcie_advanced_error_reporting aer_checker chk (.sys_clk, .sys_rst, .auxPowerRst,
  .rootMode, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .uncErrEvent, .corErrEvent, .msgValid, .msgKind, .msgAccept, .hdrLogCapture, .irq);
`default_nettype wire

// *** testbench/pcie_advanced_error_reporting_tb.sv ***
// self-checking bench for the error reporting bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module pcie_advanced_error_reporting_tb;
  import aer_pkg::*;
  logic sys_clk = 0, sys_rst = 1, auxPowerRst = 1, rootMode = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, uncErrEvent = 32'h0, corErrEvent = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0, stall = 4'h0;
  logic pready, pslverr, msgValid, msgAccept, hdrLogCapture, irq;
  msg_kind_t msgKind, lastKind;
  logic [7:0] msgCount;
  int fails = 0, nTests = 0, cycles = 0, logCnt = 0;
  pcie_advanced_error_reporting uut (.sys_clk, .sys_rst, .auxPowerRst, .rootMode, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .uncErrEvent,
    .corErrEvent, .msgValid, .msgKind, .msgAccept, .hdrLogCapture, .irq);
  root_complex_model root (.sys_clk, .sys_rst, .msgValid, .msgKind, .msgAccept, .stall,
    .lastKind, .msgCount);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (hdrLogCapture === 1'b1) logCnt++;
    if (cycles == 20000) begin
      fails++;
      test_done;
    end
  end
  // ------------------------------------------------------------
  // bus and event tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic ev(input logic [31:0] u, input logic [31:0] c);
    @(posedge sys_clk);
    uncErrEvent <= u;
    corErrEvent <= c;
    @(posedge sys_clk);
    uncErrEvent <= 32'h0;
    corErrEvent <= 32'h0;
  endtask
  task automatic waitMsg(input logic [7:0] n);
    int k;
    k = 0;
    while (msgCount !== n && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    `CHK("msgCount", n, msgCount)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rchk("capHdr", ADDR_CAP_HDR, 32'h1381_0001);
    rchk("uncSts", ADDR_UNC_STATUS, 32'h0000_2000);
    rchk("uncMask", ADDR_UNC_MASK, 32'h0040_0000);
    rchk("uncSev", ADDR_UNC_SEVERITY, 32'h0046_2030);
    rchk("corSts", ADDR_COR_STATUS, 32'h0);
    rchk("corMask", ADDR_COR_MASK, 32'h0000_E000);
    rchk("capCtrl", ADDR_CAP_CTRL, 32'h0000_001F);
    $display("test reset done");
  endtask
  task automatic t_access;
    apb(1'b1, ADDR_UNC_SEVERITY, 32'h0);
    rchk("sevRo", ADDR_UNC_SEVERITY, 32'h0000_2000);
    apb(1'b1, ADDR_UNC_SEVERITY, 32'h0046_2030);
    apb(1'b1, ADDR_UNC_MASK, 32'hFFFF_FFFF);
    rchk("maskRw", ADDR_UNC_MASK, 32'h0057_D030);
    apb(1'b1, ADDR_CAP_CTRL, 32'hFFFF_FFFF);
    rchk("ctrlRo", ADDR_CAP_CTRL, 32'h0000_001F);
    apb(1'b1, ADDR_CAP_HDR, 32'h0);
    rchk("hdrRo", ADDR_CAP_HDR, 32'h1381_0001);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    rchk("unmapped", 12'h100, 32'h0);
    $display("test access done");
  endtask
  task automatic t_masked;
    apb(1'b1, ADDR_COR_MASK, 32'hFFFF_FFFF);
    ev(32'hFFFF_FFFF, 32'hFFFF_FFFF);
    rchk("uncAll", ADDR_UNC_STATUS, 32'h0057_F030);
    rchk("corAll", ADDR_COR_STATUS, 32'h0000_F1C1);
    rchk("ptrKept", ADDR_CAP_CTRL, 32'h0000_001F);
    `CHK("noLog", 0, logCnt)
    `CHK("noMsg", 8'h0, msgCount)
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk("stickySts", ADDR_UNC_STATUS, 32'h0057_F030);
    rchk("stickyMask", ADDR_UNC_MASK, 32'h0057_D030);
    apb(1'b1, ADDR_UNC_STATUS, 32'hFFFF_FFFF);
    apb(1'b1, ADDR_COR_STATUS, 32'hFFFF_FFFF);
    rchk("uncClr", ADDR_UNC_STATUS, 32'h0000_2000);
    rchk("corClr", ADDR_COR_STATUS, 32'h0);
    $display("test masked done");
  endtask
  task automatic t_fatal;
    apb(1'b1, ADDR_UNC_MASK, 32'h0040_0000);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    stall <= 4'h5;
    ev(32'h0004_0010, 32'h0);
    waitMsg(8'h1);
    `CHK("fatalKind", MSG_FATAL, lastKind)
    `CHK("logOnce", 1, logCnt)
    `CHK("irqHigh", 1'b1, irq)
    rchk("ptr", ADDR_CAP_CTRL, 32'h0000_0004);
    rchk("uncSet", ADDR_UNC_STATUS, 32'h0004_2010);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    rchk("irqSts", ADDR_IRQ_STATUS, 32'h1);
    `CHK("irqMasked", 1'b0, irq)
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    rchk("irqClr", ADDR_IRQ_STATUS, 32'h0);
    `CHK("irqLow", 1'b0, irq)
    apb(1'b1, ADDR_UNC_STATUS, 32'hFFFF_FFFF);
    rchk("ptrFree", ADDR_CAP_CTRL, 32'h0000_001F);
    $display("test fatal done");
  endtask
  task automatic t_severity;
    apb(1'b1, ADDR_UNC_SEVERITY, 32'h0044_2030);
    apb(1'b1, ADDR_COR_MASK, 32'h0);
    stall <= 4'h0;
    ev(32'h0002_0000, 32'h0);
    waitMsg(8'h2);
    `CHK("nonFatal", MSG_NONFATAL, lastKind)
    ev(32'h0000_1000, 32'h0);
    waitMsg(8'h3);
    `CHK("advisory", MSG_COR, lastKind)
    rchk("advSts", ADDR_COR_STATUS, 32'h0000_2000);
    apb(1'b1, ADDR_UNC_SEVERITY, 32'h0044_3030);
    ev(32'h0000_1000, 32'h0);
    waitMsg(8'h4);
    `CHK("sevFatal", MSG_FATAL, lastKind)
    apb(1'b1, ADDR_UNC_STATUS, 32'hFFFF_FFFF);
    apb(1'b1, ADDR_COR_STATUS, 32'hFFFF_FFFF);
    $display("test severity done");
  endtask
  task automatic t_root;
    apb(1'b1, ADDR_ROOT_CMD, 32'h7);
    rchk("rootRsvd", ADDR_ROOT_CMD, 32'h0);
    rootMode <= 1'b1;
    apb(1'b1, ADDR_ROOT_CMD, 32'h7);
    rchk("rootCmd", ADDR_ROOT_CMD, 32'h0000_0007);
    rootMode <= 1'b0;
    apb(1'b1, ADDR_ROOT_STATUS, 32'h0);
    rchk("rootOff", ADDR_ROOT_CMD, 32'h0);
    $display("test root done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    auxPowerRst <= 1'b0;
    t_reset;
    t_access;
    t_masked;
    t_fatal;
    t_severity;
    t_root;
    test_done;
  end
endmodule
`default_nettype wire

// *** testbench/root_complex_model.sv ***
// root side taker of error messages with adjustable stall
`timescale 1ns/1ps
`default_nettype none
module root_complex_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // message
  input wire logic msgValid,
  input wire aer_pkg::msg_kind_t msgKind,
  output logic msgAccept,
  // control and record
  input wire logic [3:0] stall,
  output aer_pkg::msg_kind_t lastKind,
  output logic [7:0] msgCount
);
  logic [3:0] cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      msgAccept <= 1'b0;
      cnt_ff <= 4'h0;
      msgCount <= 8'h0;
      lastKind <= aer_pkg::MSG_COR;
    end else begin
      msgAccept <= 1'b0;
      if (msgValid && msgAccept) begin
        lastKind <= msgKind;
        msgCount <= msgCount + 8'h1;
        cnt_ff <= 4'h0;
      end else if (msgValid) begin
        if (cnt_ff == stall) begin
          msgAccept <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire
